// *** rtl/fpd_ctrl.sv ***
// Power-down, ultra power-down, resume and lock framing control of a serial flash.
// Assumes a host drives cs_n, sclk and si; busy, select and latch come from core logic.
`timescale 1ns/10ps
`include "fpd_cfg.svh"
module fpd_ctrl #(
	parameter int         SLEEP_ENTRY_CYC = `FPD_SLEEP_ENTRY_CYC,
	parameter int         SLEEP_EXIT_CYC  = `FPD_SLEEP_EXIT_CYC,
	parameter int         ULTRA_ENTRY_CYC = `FPD_ULTRA_ENTRY_CYC,
	parameter int         ULTRA_EXIT_CYC  = `FPD_ULTRA_EXIT_CYC,
	parameter logic [7:0] DEVICE_ID       = `FPD_DEVICE_ID
)(
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  sclk,
	input  wire logic  cs_n,
	input  wire logic  si,
	output logic       so,
	output logic       so_oe,
	input  wire logic  powerdown_depth_select,
	input  wire logic  operation_in_progress_flag,
	input  wire logic  write_permit_latch,
	output logic       deep_sleep_state,
	output logic       ultra_sleep_state,
	output logic       standby_ready,
	output logic       lock_pulse,
	output logic       sram_reset_pulse,
	output logic       cmd_fwd_pulse,
	output logic [7:0] cmd_fwd_code
);
	import fpd_pkg::*;

	// ------------------------------------------------------------
	// Link domain: shift in on rising sclk
	// ------------------------------------------------------------
	logic       first_r;
	logic [2:0] bit_r;
	logic [2:0] byte_r;
	logic [7:0] sh_r;
	logic [7:0] op_r;
	logic [7:0] b1_r;
	logic [7:0] b2_r;
	logic       frame_tgl_r;
	logic [2:0] bitpos;
	logic [2:0] bytepos;
	logic [7:0] sh_nxt;
	logic       ultra_link;
	logic       so_r;
	logic       so_oe_r;

	assign bitpos  = first_r ? 3'h0 : bit_r;
	assign bytepos = first_r ? 3'h0 : byte_r;
	assign sh_nxt  = {sh_r[6:0], si};

	// Clock is stopped outside frames, so frame start is marked by cs_n
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
			first_r <= 1'b1;
		else
			first_r <= 1'b0;
	end

	// Core reset clears the marker; sclk stands still while rst is high
	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
			frame_tgl_r <= 1'b0;
		else if (first_r)
			frame_tgl_r <= ~frame_tgl_r;
	end

	always_ff @(posedge sclk)
	begin
		sh_r  <= sh_nxt; // R4
		bit_r <= bitpos + 3'h1;
		if (bitpos == 3'h7 && bytepos != `FPD_BYTE_MAX)
			byte_r <= bytepos + 3'h1;
		else
			byte_r <= bytepos;
	end

	// Fields stay put after release until the next frame's eighth clock
	always_ff @(posedge sclk)
	begin
		if (bitpos == 3'h7 && bytepos == 3'h0)
			op_r <= sh_nxt; // R4
		if (bitpos == 3'h7 && bytepos == 3'h1)
			b1_r <= sh_nxt;
		if (bitpos == 3'h7 && bytepos == 3'h2)
			b2_r <= sh_nxt;
	end

	fpd_sync #(
		.WIDTH   (1),
		.RST_VAL (2'b00)
	) u_sync_link (
		.clk (sclk),
		.rst (1'b0),
		.d   (ultra_sleep_state),
		.q   (ultra_link)
	);

	// Identifier on falling sclk after the dummy bytes; quiet in ultra sleep
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			so_r    <= 1'b0;
			so_oe_r <= 1'b0;
		end
		else
		begin
			so_r    <= DEVICE_ID[~bit_r]; // R13
			so_oe_r <= !first_r && (byte_r >= `FPD_ID_BYTE) && (op_r == `FPD_OP_RESUME) && !ultra_link; // R12 R10 R18
		end
	end

	assign so    = so_r;
	assign so_oe = so_oe_r;

	// ------------------------------------------------------------
	// Crossing of release and frame marker into the core domain
	// ------------------------------------------------------------
	logic [1:0] sync_q;
	logic       cs_d_r;
	logic       seen_tgl_r;
	logic       frame_end;
	logic       clocked;
	logic       aligned;
	logic [2:0] nbytes;

	fpd_sync #(
		.WIDTH   (2),
		.RST_VAL (`FPD_SYNC_RST)
	) u_sync_core (
		.clk (clock),
		.rst (rst),
		.d   ({cs_n, frame_tgl_r}),
		.q   (sync_q)
	);

	always_ff @(posedge clock)
	begin
		if (rst)
			cs_d_r <= 1'b1;
		else
			cs_d_r <= sync_q[1];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			seen_tgl_r <= 1'b0;
		else if (frame_end)
			seen_tgl_r <= sync_q[0];
	end

	assign frame_end = sync_q[1] && !cs_d_r;
	assign clocked   = sync_q[0] != seen_tgl_r;
	assign aligned   = clocked && (bit_r == 3'h0); // R3
	assign nbytes    = clocked ? byte_r : 3'h0;

	// ------------------------------------------------------------
	// Command decode at release
	// ------------------------------------------------------------
	fpd_state_t state_r;
	fpd_state_t state_nxt;
	logic       lock_ok;
	logic       sleep_ok;
	logic       ultra_ok;
	logic       resume_ok;
	logic       fwd_ok;
	logic       is_reset_op;
	logic       is_own_op;

	assign is_reset_op = (op_r == `FPD_OP_RST_EN) || (op_r == `FPD_OP_RST);
	assign is_own_op   = (op_r == `FPD_OP_LOCK) || (op_r == `FPD_OP_SLEEP) ||
	                     (op_r == `FPD_OP_ULTRA) || (op_r == `FPD_OP_RESUME);

	assign lock_ok   = aligned && (op_r == `FPD_OP_LOCK) && (nbytes == `FPD_LOCK_BYTES) && // R1 R2
	                   (b1_r == `FPD_LOCK_KEY1) && (b2_r == `FPD_LOCK_KEY2) && // R17
	                   write_permit_latch && (state_r == ST_STANDBY); // R16
	assign sleep_ok  = aligned && (op_r == `FPD_OP_SLEEP) && (nbytes == `FPD_PLAIN_BYTES) && // R6
	                   !operation_in_progress_flag; // R8
	assign ultra_ok  = aligned && (op_r == `FPD_OP_ULTRA) && !operation_in_progress_flag;
	assign resume_ok = aligned && (op_r == `FPD_OP_RESUME) && (nbytes != 3'h0); // R2
	assign fwd_ok    = aligned && !is_own_op &&
	                   ((state_r == ST_STANDBY) || ((state_r == ST_DEEP) && is_reset_op)); // R9 R18

	// ------------------------------------------------------------
	// Power mode sequencing
	// ------------------------------------------------------------
	logic [15:0] timer_r;
	logic        timer_done;

	assign timer_done = timer_r == 16'h0000;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_STANDBY:
				if (frame_end && sleep_ok)
					state_nxt = powerdown_depth_select ? ST_ENTER_DEEP : ST_ENTER_ULTRA; // R5 R15 R7
				else if (frame_end && ultra_ok)
					state_nxt = ST_ENTER_ULTRA; // R15
			ST_ENTER_DEEP:
				if (timer_done)
					state_nxt = ST_DEEP; // R7
			ST_DEEP:
				if (frame_end && resume_ok)
					state_nxt = ST_EXIT_DEEP; // R10 R11
			ST_EXIT_DEEP:
				if (timer_done)
					state_nxt = ST_STANDBY; // R11
			ST_ENTER_ULTRA:
				if (timer_done)
					state_nxt = ST_ULTRA;
			ST_ULTRA:
				if (frame_end && resume_ok)
					state_nxt = ST_EXIT_ULTRA; // R10 R14
			ST_EXIT_ULTRA:
				if (timer_done)
					state_nxt = ST_STANDBY; // R14
			default:
				state_nxt = ST_STANDBY;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state_r <= ST_STANDBY;
		else
			state_r <= state_nxt;
	end

	// Loads two short so the target state lands on the last allowed cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			timer_r <= 16'h0000;
		else if (state_nxt != state_r)
			unique case (state_nxt)
				ST_ENTER_DEEP:  timer_r <= 16'(SLEEP_ENTRY_CYC - 2);
				ST_EXIT_DEEP:   timer_r <= 16'(SLEEP_EXIT_CYC - 2);
				ST_ENTER_ULTRA: timer_r <= 16'(ULTRA_ENTRY_CYC - 2);
				ST_EXIT_ULTRA:  timer_r <= 16'(ULTRA_EXIT_CYC - 2);
				default:        timer_r <= 16'h0000;
			endcase
		else if (!timer_done)
			timer_r <= timer_r - 16'h0001;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic       deep_r;
	logic       ultra_r;
	logic       ready_r;
	logic       lock_r;
	logic       sram_rst_r;
	logic       fwd_r;
	logic [7:0] fwd_code_r;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			deep_r  <= 1'b0;
			ultra_r <= 1'b0;
			ready_r <= 1'b0;
		end
		else
		begin
			deep_r  <= state_r == ST_DEEP;
			ultra_r <= state_r == ST_ULTRA;
			ready_r <= state_r == ST_STANDBY;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			lock_r <= 1'b0;
		else
			lock_r <= frame_end && lock_ok; // R1 R16 R17
	end

	// SRAM contents are dropped at the release that wakes from ultra sleep
	always_ff @(posedge clock)
	begin
		if (rst)
			sram_rst_r <= 1'b0;
		else
			sram_rst_r <= frame_end && resume_ok && (state_r == ST_ULTRA); // R14
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			fwd_r      <= 1'b0;
			fwd_code_r <= 8'h00;
		end
		else
		begin
			fwd_r <= frame_end && fwd_ok; // R9
			if (frame_end && fwd_ok)
				fwd_code_r <= op_r;
		end
	end

	assign deep_sleep_state  = deep_r;
	assign ultra_sleep_state = ultra_r;
	assign standby_ready     = ready_r;
	assign lock_pulse        = lock_r;
	assign sram_reset_pulse  = sram_rst_r;
	assign cmd_fwd_pulse     = fwd_r;
	assign cmd_fwd_code      = fwd_code_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	localparam int AST_SE = SLEEP_ENTRY_CYC + 2;
	localparam int AST_SX = SLEEP_EXIT_CYC + 2;
	localparam int AST_UE = ULTRA_ENTRY_CYC + 2;
	localparam int AST_UX = ULTRA_EXIT_CYC + 2;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_LOCK_CAUSE: assert property ( // R1 R16 R17
		lock_r |-> $past(frame_end && aligned && nbytes == `FPD_LOCK_BYTES && b1_r == `FPD_LOCK_KEY1 &&
		                 b2_r == `FPD_LOCK_KEY2 && write_permit_latch))
		else $error("lock without full keyed sequence");
	AST_UNALIGNED_NOOP: assert property ( // R3 R2
		frame_end && !aligned |=> !lock_r && !sram_rst_r && !fwd_r && state_r == $past(state_r))
		else $error("partial byte frame changed state");
	AST_DEEP_ENTRY: assert property ( // R5 R7
		frame_end && sleep_ok && powerdown_depth_select && state_r == ST_STANDBY
		|=> state_r == ST_ENTER_DEEP ##[1:AST_SE] deep_r)
		else $error("deep sleep not reached in time");
	AST_BUSY_IGNORE: assert property ( // R8
		frame_end && state_r == ST_STANDBY && op_r == `FPD_OP_SLEEP && operation_in_progress_flag
		|=> state_r == ST_STANDBY)
		else $error("power-down taken while busy");
	AST_DEEP_FILTER: assert property ( // R9
		fwd_r && $past(state_r) == ST_DEEP |-> (fwd_code_r == `FPD_OP_RST_EN || fwd_code_r == `FPD_OP_RST))
		else $error("command passed in deep sleep");
	AST_DEEP_WAKE: assert property ( // R10 R11
		frame_end && resume_ok && state_r == ST_DEEP |=> !sram_rst_r ##[1:AST_SX] ready_r)
		else $error("deep wake not finished in time");
	AST_ULTRA_WAKE: assert property ( // R14
		frame_end && resume_ok && state_r == ST_ULTRA |=> sram_rst_r ##[1:AST_UX] ready_r)
		else $error("ultra wake missing reset or late");
	AST_ULTRA_ENTRY: assert property ( // R15
		frame_end && state_r == ST_STANDBY && (ultra_ok || (sleep_ok && !powerdown_depth_select))
		|-> ##[2:AST_UE] ultra_r)
		else $error("ultra sleep not reached in time");
	AST_ULTRA_SILENT: assert property ( // R18
		ultra_r |-> !fwd_r && !lock_r && !so_oe_r)
		else $error("activity while in ultra sleep");
	AST_ID_BIT: assert property ( // R13
		@(negedge sclk) disable iff (cs_n)
		so_oe_r |-> so_r == DEVICE_ID[~$past(bit_r)])
		else $error("identifier bit out of order");
endmodule

// *** rtl/fpd_cfg.svh ***
// Constants for the flash power-down and resume command control.
// Assumes SPI mode 0 or 3 framing on the link and a 100 MHz core clock.
//
// How it works
// R1 - Lock needs opcode plus exactly two bytes
// R2 - Early chip select release discards lock, resume
// R3 - Partial byte at release aborts, nothing changes
// R4 - Opcode shifted in eight clocks, MSB first
// R5 - Power-down with select bit set enters deep sleep
// R6 - Power-down is a single opcode byte only
// R7 - Deep sleep entry starts at release, bounded
// R8 - Power-down ignored while program or erase busy
// R9 - Deep sleep accepts only resume and resets
// R10 - Resume action depends on current sleep mode
// R11 - Plain wake leaves deep sleep within bound
// R12 - Identifier readout waits through three dummy bytes
// R13 - Identifier repeats MSB first until release
// R14 - Ultra wake resets internal SRAM, then standby
// R15 - Ultra entry by own opcode or select clear
// R16 - Lock needs the write permit latch set
// R17 - Lock bytes must be both patterns in order
// R18 - Ignored commands leave output and state untouched
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH

// ----------------------------------------------------------------
// Opcodes and patterns
// ----------------------------------------------------------------
`define FPD_OP_LOCK      8'h6f
`define FPD_OP_SLEEP     8'hb9
`define FPD_OP_ULTRA     8'h79
`define FPD_OP_RESUME    8'hab
`define FPD_OP_RST_EN    8'h66
`define FPD_OP_RST       8'h99
`define FPD_LOCK_KEY1    8'h4d
`define FPD_LOCK_KEY2    8'h67
`define FPD_LOCK_BYTES   3'h3
`define FPD_PLAIN_BYTES  3'h1
`define FPD_ID_BYTE      3'h4
`define FPD_BYTE_MAX     3'h7
// Arbitrary identifier value
`define FPD_DEVICE_ID    8'h5a

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPD_CLK_MHZ              100
`define FPD_SLEEP_ENTRY_NS       3000
`define FPD_SLEEP_EXIT_NS        3000
`define FPD_ULTRA_ENTRY_NS       3000
`define FPD_ULTRA_EXIT_NS        8000
`define FPD_SLEEP_ENTRY_CYC      ((`FPD_SLEEP_ENTRY_NS * `FPD_CLK_MHZ) / 1000)
`define FPD_SLEEP_EXIT_CYC       ((`FPD_SLEEP_EXIT_NS * `FPD_CLK_MHZ) / 1000)
`define FPD_ULTRA_ENTRY_CYC      ((`FPD_ULTRA_ENTRY_NS * `FPD_CLK_MHZ) / 1000)
`define FPD_ULTRA_EXIT_CYC       ((`FPD_ULTRA_EXIT_NS * `FPD_CLK_MHZ) / 1000)
`define FPD_SYNC_RST             2'b10

`endif

// *** rtl/fpd_pkg.sv ***
// Types for the flash power-down and resume command control.
// Assumes the constants header is included alongside.
package fpd_pkg;

	// ------------------------------------------------------------
	// Power mode states
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_STANDBY     = 3'h0,
		ST_ENTER_DEEP  = 3'h1,
		ST_DEEP        = 3'h2,
		ST_EXIT_DEEP   = 3'h3,
		ST_ENTER_ULTRA = 3'h4,
		ST_ULTRA       = 3'h5,
		ST_EXIT_ULTRA  = 3'h6
	} fpd_state_t;

endpackage

// *** rtl/fpd_sync.sv ***
// Two flip-flop level synchroniser, one per bit.
// Assumes each bit is a level or a toggle that holds for two destination edges.
`timescale 1ns/10ps
module fpd_sync #(
	parameter int         WIDTH   = 1,
	parameter logic [1:0] RST_VAL = 2'b00
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// Only the second stage is read
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= RST_VAL[WIDTH-1:0];
			q      <= RST_VAL[WIDTH-1:0];
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// *** sim/fpd_host_model.sv ***
// Host controller model that frames commands on the serial link.
// Assumes the device samples si on rising sclk and drives so on falling sclk.
`timescale 1ns/10ps
module fpd_host_model #(
	parameter int HALF = 6
)(
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	initial
	begin
		sclk = 1'b0;
		si   = 1'b0;
		// A late rising edge presets the link flags once the design is waiting for it
		#1 cs_n = 1'b1;
	end

	// ------------------------------------------------------------
	// One frame, data right aligned, nbits long
	// ------------------------------------------------------------
	task automatic xfer(input logic [55:0] data, input int nbits, output logic [15:0] rx, output logic oe_seen);
		int i;
		rx      = 16'h0000;
		oe_seen = 1'b0;
		cs_n    = 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			si = data[nbits-1-i];
			#HALF sclk = 1'b1;
			if (i >= 32)
				rx = {rx[14:0], so};
			oe_seen = oe_seen | (so_oe === 1'b1);
			#HALF sclk = 1'b0;
		end
		// Release only after the count asked for; clock stands still between frames
		#HALF cs_n = 1'b1;
		si = ~si;
		// Gap lets the core read the frame record
		#60;
	endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the power-down, resume and lock control.
// Assumes the host model frames every command; core flags driven here.
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] ID = 8'h3c;
	logic        clock, rst, sclk, cs_n, si, so, so_oe, sel, busy, lat;
	logic        deep_sleep_state, ultra_sleep_state, standby_ready;
	logic        lock_pulse, sram_reset_pulse, cmd_fwd_pulse, oe;
	logic [7:0]  cmd_fwd_code;
	logic [15:0] rx;
	logic [2:0]  mode;
	int          err_total, comparisons, n_lock, n_sram, n_fwd;

	assign mode = {ultra_sleep_state, deep_sleep_state, standby_ready};

	fpd_ctrl #(.SLEEP_ENTRY_CYC(4), .SLEEP_EXIT_CYC(4), .ULTRA_ENTRY_CYC(4), .ULTRA_EXIT_CYC(6),
		.DEVICE_ID(ID)) u_fpd_ctrl (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe), .powerdown_depth_select(sel), .operation_in_progress_flag(busy),
		.write_permit_latch(lat), .deep_sleep_state(deep_sleep_state),
		.ultra_sleep_state(ultra_sleep_state), .standby_ready(standby_ready), .lock_pulse(lock_pulse),
		.sram_reset_pulse(sram_reset_pulse), .cmd_fwd_pulse(cmd_fwd_pulse), .cmd_fwd_code(cmd_fwd_code));

	fpd_host_model u_fpd_host_model (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		n_lock += (lock_pulse === 1'b1);
		n_sram += (sram_reset_pulse === 1'b1);
		n_fwd  += (cmd_fwd_pulse === 1'b1);
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic set_in(input logic s, input logic b, input logic l);
		@(posedge clock);
		sel  <= s;
		busy <= b;
		lat  <= l;
		@(posedge clock);
	endtask

	// Settle long enough for any entry or exit to finish
	task automatic send(input logic [55:0] d, input int n);
		u_fpd_host_model.xfer(d, n, rx, oe);
		repeat (20) @(posedge clock);
	endtask

	task automatic await(input logic [2:0] exp);
		int i;
		i = 0;
		while (mode !== exp && i < 60)
		begin
			@(posedge clock);
			i++;
		end
		if (mode !== exp)
		begin
			err_total++;
			$display("unexpected mode wait expected %h seen %h", exp, mode);
			conclude();
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_lock();
		send(56'h6f4d67, 24);
		check("lock without latch", 16'(n_lock), 16'h0000);
		set_in(1'b1, 1'b0, 1'b1);
		send(56'h6f4d, 16);
		check("lock short", 16'(n_lock), 16'h0000);
		send(56'h37a6b3, 23);
		check("lock partial byte", 16'(n_lock), 16'h0000);
		send(56'h6f674d, 24);
		check("lock keys swapped", 16'(n_lock), 16'h0000);
		send(56'h6f4d67, 24);
		check("lock done", 16'(n_lock), 16'h0001);
		$display("test lock done");
	endtask

	task automatic t_fwd_ident();
		send(56'h03, 8);
		check("fwd count", 16'(n_fwd), 16'h0001);
		check("fwd code", {8'h00, cmd_fwd_code}, 16'h0003);
		send(56'hab0000000000, 48);
		check("standby id", rx, {ID, ID});
		check("standby mode", {13'h0000, mode}, 16'h0001);
		$display("test forward and id done");
	endtask

	task automatic t_deep();
		set_in(1'b1, 1'b1, 1'b0);
		send(56'hb9, 8);
		check("sleep while busy", {13'h0000, mode}, 16'h0001);
		set_in(1'b1, 1'b0, 1'b0);
		send(56'h172, 9);
		check("sleep partial", {13'h0000, mode}, 16'h0001);
		send(56'hb900, 16);
		check("sleep extra byte", {13'h0000, mode}, 16'h0001);
		send(56'hb9, 8);
		await(3'b010);
		check("deep entered", {13'h0000, mode}, 16'h0002);
		send(56'h05, 8);
		check("deep status read fwd", 16'(n_fwd), 16'h0001);
		check("deep status read so", {15'h0000, oe}, 16'h0000);
		send(56'h66, 8);
		check("deep reset enable fwd", 16'(n_fwd), 16'h0002);
		check("deep reset enable code", {8'h00, cmd_fwd_code}, 16'h0066);
		send(56'h99, 8);
		check("deep reset fwd", 16'(n_fwd), 16'h0003);
		check("deep reset code", {8'h00, cmd_fwd_code}, 16'h0099);
		send(56'h55, 7);
		check("resume partial", {13'h0000, mode}, 16'h0002);
		send(56'hab, 8);
		await(3'b001);
		check("plain wake", {13'h0000, mode}, 16'h0001);
		send(56'h05, 8);
		check("wake accepts command", 16'(n_fwd), 16'h0004);
		check("wake command code", {8'h00, cmd_fwd_code}, 16'h0005);
		send(56'hb9, 8);
		await(3'b010);
		send(56'hab0000000000, 48);
		check("deep id", rx, {ID, ID});
		await(3'b001);
		check("id wake", {13'h0000, mode}, 16'h0001);
		$display("test deep sleep done");
	endtask

	task automatic t_ultra();
		set_in(1'b0, 1'b0, 1'b0);
		send(56'hb9, 8);
		await(3'b100);
		check("ultra by select", {13'h0000, mode}, 16'h0004);
		send(56'h66, 8);
		check("ultra fwd", 16'(n_fwd), 16'h0004);
		send(56'hab0000000000, 48);
		check("ultra no id", {15'h0000, oe}, 16'h0000);
		await(3'b001);
		check("ultra sram reset", 16'(n_sram), 16'h0001);
		send(56'h79, 8);
		await(3'b100);
		check("ultra by opcode", {13'h0000, mode}, 16'h0004);
		send(56'hab, 8);
		await(3'b001);
		check("ultra wake", 16'(n_sram), 16'h0002);
		$display("test ultra sleep done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		sel = 1'b1;
		busy = 1'b0;
		lat = 1'b0;
		err_total = 0;
		comparisons = 0;
		n_lock = 0;
		n_sram = 0;
		n_fwd = 0;
		// Two edges load the core synchroniser flops with their reset value as well
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		check("reset mode", {13'h0000, mode}, 16'h0001);
		t_lock();
		t_fwd_ident();
		t_deep();
		t_ultra();
		conclude();
	end
endmodule
